// ===== logic/zcdl_consts.svh
// Register offsets, field positions and reset values of the zero-cross logic
// Assumes inclusion by bare name from the design modules and the bench
`ifndef ZCDL_CONSTS_SVH
`define ZCDL_CONSTS_SVH
`define ZCDL_ADDR_W       8
`define ZCDL_OFF_CTRL     8'h00
`define ZCDL_OFF_FLAG     8'h04
`define ZCDL_OFF_IEN      8'h08
`define ZCDL_OFF_ICTL     8'h0C
`define ZCDL_OFF_STAT     8'h10
`define ZCDL_BIT_EN       7
`define ZCDL_BIT_OUT      5
`define ZCDL_BIT_POL      4
`define ZCDL_BIT_RISE     1
`define ZCDL_BIT_FALL     0
`define ZCDL_BIT_FLAG     0
`define ZCDL_BIT_IE       0
`define ZCDL_BIT_GIE      7
`define ZCDL_BIT_PERIPHERAL_GROUP_IRQ_ENABLE     6
`define ZCDL_BIT_CFG      0
`define ZCDL_BIT_ACT      1
`define ZCDL_RST_BIT      1'b0
`define ZCDL_RST_CFG      1'b1
`define ZCDL_RST_WORD     32'h00000000
`define ZCDL_RESP_OKAY    2'h0
`define ZCDL_RESP_SLVERR  2'h2
`define ZCDL_SYNC_STAGES  2
`endif

// ===== logic/zcdl_pkg.sv
// Types used by the zero-cross logic top module
// Assumes the constants header is compiled alongside
package zcdl_pkg;
  typedef enum logic [2:0] {
    zcdl_reg_ctrl,
    zcdl_reg_flag,
    zcdl_reg_ien,
    zcdl_reg_ictl,
    zcdl_reg_stat,
    zcdl_reg_none
  } zcdl_reg_t;
  typedef enum logic [1:0] {
    zcdl_wr_idle,
    zcdl_wr_addr,
    zcdl_wr_data,
    zcdl_wr_resp
  } zcdl_wr_state_t;
  typedef enum logic {
    zcdl_rd_idle,
    zcdl_rd_resp
  } zcdl_rd_state_t;
endpackage

// ===== logic/zcdl_sync.sv
// Two-stage synchroniser for the raw sink/source indication
// Assumes the input is asynchronous to aclk
`include "zcdl_consts.svh"
module zcdl_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic [`ZCDL_SYNC_STAGES-1:0] stage;
  logic [`ZCDL_SYNC_STAGES-1:0] next_stage;

  // Shift chain; only the last stage is read outside
  always_comb begin
    next_stage = {stage[`ZCDL_SYNC_STAGES-2:0], async_in};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign sync_out = stage[`ZCDL_SYNC_STAGES-1];
endmodule

// ===== logic/zcdl_edge.sv
// Rising and falling edge detector on the detector output level
// Assumes the level is synchronous to aclk
`include "zcdl_consts.svh"
module zcdl_edge (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev;
  logic next_prev;

  always_comb begin
    next_prev = level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= `ZCDL_RST_BIT;
    end else begin
      prev <= next_prev;
    end
  end

  // Separate detectors for each direction
  assign rise = level & ~prev;
  assign fall = ~level & prev;

  a_edge_exclusive: assert property (
    @(posedge aclk) disable iff (!aresetn) rise |-> !fall ##1 !rise)
    else $error("edge detector fired twice");
endmodule

// ===== logic/zcdl_top.sv
// Zero-cross detector digital logic with AXI4-Lite register access
// Assumes a sense stage drives sense_sink and obeys sense_enable
//
// Local design decisions: register access over AXI4-Lite and the address map.
`include "zcdl_consts.svh"
module zcdl_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sense_sink,
  input  wire logic        por_config_bit,
  output logic             sense_enable,
  output logic             crossing_level,
  output logic             irq
);
  zcdl_pkg::zcdl_wr_state_t wr_state;
  zcdl_pkg::zcdl_wr_state_t next_wr_state;
  zcdl_pkg::zcdl_rd_state_t rd_state;
  zcdl_pkg::zcdl_rd_state_t next_rd_state;
  zcdl_pkg::zcdl_reg_t      wr_sel;
  zcdl_pkg::zcdl_reg_t      rd_sel;
  logic [7:0]               wr_addr;
  logic [7:0]               next_wr_addr;
  logic [31:0]              wr_data;
  logic [31:0]              next_wr_data;
  logic [3:0]               wr_strb;
  logic [3:0]               next_wr_strb;
  logic [1:0]               bresp;
  logic [1:0]               next_bresp;
  logic [31:0]              rdata;
  logic [31:0]              next_rdata;
  logic [1:0]               rresp;
  logic [1:0]               next_rresp;
  logic                     wr_fire;
  logic [7:0]               use_addr;
  logic [31:0]              use_data;
  logic [3:0]               use_strb;
  logic                     wr_lane0;
  logic                     en;
  logic                     next_en;
  logic                     level_invert_bit;
  logic                     next_pol;
  logic                     rise_en;
  logic                     next_rise_en;
  logic                     fall_en;
  logic                     next_fall_en;
  logic                     flag;
  logic                     next_flag;
  logic                     ie;
  logic                     next_ie;
  logic                     global_irq_enable;
  logic                     next_gie;
  logic                     peripheral_group_irq_enable;
  logic                     next_peripheral_group_irq_enable;
  logic                     por_cfg;
  logic                     next_por_cfg;
  logic                     por_cfg_valid;
  logic                     next_por_cfg_valid;
  logic                     next_sense_enable;
  logic                     raw_sync;
  logic                     level;
  logic                     rise;
  logic                     fall;
  logic                     set_evt;
  logic                     clr_evt;
  logic                     detector_active;

  // Register decode shared by the write and read paths
  function automatic zcdl_pkg::zcdl_reg_t reg_decode(input logic [7:0] addr);
    zcdl_pkg::zcdl_reg_t sel;
    case (addr)
      `ZCDL_OFF_CTRL: sel = zcdl_pkg::zcdl_reg_ctrl;
      `ZCDL_OFF_FLAG: sel = zcdl_pkg::zcdl_reg_flag;
      `ZCDL_OFF_IEN:  sel = zcdl_pkg::zcdl_reg_ien;
      `ZCDL_OFF_ICTL: sel = zcdl_pkg::zcdl_reg_ictl;
      `ZCDL_OFF_STAT: sel = zcdl_pkg::zcdl_reg_stat;
      default:        sel = zcdl_pkg::zcdl_reg_none;
    endcase
    return sel;
  endfunction

  // Raw indication: one while sinking above the reference, zero while sourcing
  zcdl_sync u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (sense_sink),
    .sync_out (raw_sync)
  );

  // Polarity applied after synchronisation; the result feeds readback and edges
  assign level = raw_sync ^ level_invert_bit;

  zcdl_edge u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (level),
    .rise    (rise),
    .fall    (fall)
  );

  // Write channel: address and data accepted in either order
  assign s_axi_awready = (wr_state == zcdl_pkg::zcdl_wr_idle) ||
                         (wr_state == zcdl_pkg::zcdl_wr_data);
  assign s_axi_wready  = (wr_state == zcdl_pkg::zcdl_wr_idle) ||
                         (wr_state == zcdl_pkg::zcdl_wr_addr);
  assign s_axi_bvalid  = (wr_state == zcdl_pkg::zcdl_wr_resp);
  assign s_axi_bresp   = bresp;

  always_comb begin
    next_wr_state = wr_state;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    next_wr_strb  = wr_strb;
    next_bresp    = bresp;
    wr_fire       = 1'b0;
    use_addr      = wr_addr;
    use_data      = wr_data;
    use_strb      = wr_strb;
    case (wr_state)
      zcdl_pkg::zcdl_wr_idle: begin
        use_addr = s_axi_awaddr;
        use_data = s_axi_wdata;
        use_strb = s_axi_wstrb;
        if (s_axi_awvalid && s_axi_wvalid) begin
          wr_fire       = 1'b1;
          next_wr_state = zcdl_pkg::zcdl_wr_resp;
        end else if (s_axi_awvalid) begin
          next_wr_addr  = s_axi_awaddr;
          next_wr_state = zcdl_pkg::zcdl_wr_addr;
        end else if (s_axi_wvalid) begin
          next_wr_data  = s_axi_wdata;
          next_wr_strb  = s_axi_wstrb;
          next_wr_state = zcdl_pkg::zcdl_wr_data;
        end
      end
      zcdl_pkg::zcdl_wr_addr: begin
        use_data = s_axi_wdata;
        use_strb = s_axi_wstrb;
        if (s_axi_wvalid) begin
          wr_fire       = 1'b1;
          next_wr_state = zcdl_pkg::zcdl_wr_resp;
        end
      end
      zcdl_pkg::zcdl_wr_data: begin
        use_addr = s_axi_awaddr;
        if (s_axi_awvalid) begin
          wr_fire       = 1'b1;
          next_wr_state = zcdl_pkg::zcdl_wr_resp;
        end
      end
      zcdl_pkg::zcdl_wr_resp: begin
        if (s_axi_bready) begin
          next_wr_state = zcdl_pkg::zcdl_wr_idle;
        end
      end
      default: begin
        next_wr_state = zcdl_pkg::zcdl_wr_idle;
      end
    endcase
    if (wr_fire) begin
      next_bresp = (reg_decode(use_addr) == zcdl_pkg::zcdl_reg_none) ?
                   `ZCDL_RESP_SLVERR : `ZCDL_RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= zcdl_pkg::zcdl_wr_idle;
      wr_addr  <= '0;
      wr_data  <= `ZCDL_RST_WORD;
      wr_strb  <= '0;
      bresp    <= `ZCDL_RESP_OKAY;
    end else begin
      wr_state <= next_wr_state;
      wr_addr  <= next_wr_addr;
      wr_data  <= next_wr_data;
      wr_strb  <= next_wr_strb;
      bresp    <= next_bresp;
    end
  end

  // Read channel: one outstanding read, answered the cycle after the address
  assign s_axi_arready = (rd_state == zcdl_pkg::zcdl_rd_idle);
  assign s_axi_rvalid  = (rd_state == zcdl_pkg::zcdl_rd_resp);
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign rd_sel        = reg_decode(s_axi_araddr);

  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    case (rd_state)
      zcdl_pkg::zcdl_rd_idle: begin
        if (s_axi_arvalid) begin
          next_rd_state = zcdl_pkg::zcdl_rd_resp;
          next_rdata    = `ZCDL_RST_WORD;
          next_rresp    = `ZCDL_RESP_OKAY;
          case (rd_sel)
            zcdl_pkg::zcdl_reg_ctrl: begin
              next_rdata[`ZCDL_BIT_EN]   = en;
              next_rdata[`ZCDL_BIT_OUT]  = level;
              next_rdata[`ZCDL_BIT_POL]  = level_invert_bit;
              next_rdata[`ZCDL_BIT_RISE] = rise_en;
              next_rdata[`ZCDL_BIT_FALL] = fall_en;
            end
            zcdl_pkg::zcdl_reg_flag: next_rdata[`ZCDL_BIT_FLAG] = flag;
            zcdl_pkg::zcdl_reg_ien:  next_rdata[`ZCDL_BIT_IE] = ie;
            zcdl_pkg::zcdl_reg_ictl: begin
              next_rdata[`ZCDL_BIT_GIE]  = global_irq_enable;
              next_rdata[`ZCDL_BIT_PERIPHERAL_GROUP_IRQ_ENABLE] = peripheral_group_irq_enable;
            end
            zcdl_pkg::zcdl_reg_stat: begin
              next_rdata[`ZCDL_BIT_CFG] = por_cfg;
              next_rdata[`ZCDL_BIT_ACT] = detector_active;
            end
            default: next_rresp = `ZCDL_RESP_SLVERR;
          endcase
        end
      end
      zcdl_pkg::zcdl_rd_resp: begin
        if (s_axi_rready) begin
          next_rd_state = zcdl_pkg::zcdl_rd_idle;
        end
      end
      default: begin
        next_rd_state = zcdl_pkg::zcdl_rd_idle;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= zcdl_pkg::zcdl_rd_idle;
      rdata    <= `ZCDL_RST_WORD;
      rresp    <= `ZCDL_RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

  // Control, flag and enable registers
  assign wr_sel   = reg_decode(use_addr);
  assign wr_lane0 = wr_fire & use_strb[0];
  assign set_evt  = (rise & rise_en) | (fall & fall_en);
  assign clr_evt  = wr_lane0 && (wr_sel == zcdl_pkg::zcdl_reg_flag) &&
                    use_data[`ZCDL_BIT_FLAG];

  always_comb begin
    next_en      = en;
    next_pol     = level_invert_bit;
    next_rise_en = rise_en;
    next_fall_en = fall_en;
    next_ie      = ie;
    next_gie     = global_irq_enable;
    next_peripheral_group_irq_enable    = peripheral_group_irq_enable;
    if (wr_lane0 && (wr_sel == zcdl_pkg::zcdl_reg_ctrl)) begin
      next_en      = use_data[`ZCDL_BIT_EN];
      next_pol     = use_data[`ZCDL_BIT_POL];
      next_rise_en = use_data[`ZCDL_BIT_RISE];
      next_fall_en = use_data[`ZCDL_BIT_FALL];
    end
    if (wr_lane0 && (wr_sel == zcdl_pkg::zcdl_reg_ien)) begin
      next_ie = use_data[`ZCDL_BIT_IE];
    end
    if (wr_lane0 && (wr_sel == zcdl_pkg::zcdl_reg_ictl)) begin
      next_gie  = use_data[`ZCDL_BIT_GIE];
      next_peripheral_group_irq_enable = use_data[`ZCDL_BIT_PERIPHERAL_GROUP_IRQ_ENABLE];
    end
    // Only a software clear drops the flag, and a new edge wins over it
    next_flag = (flag & ~clr_evt) | set_evt;
  end

  // Configuration bit caught in the first cycle after reset release
  always_comb begin
    next_por_cfg       = por_cfg_valid ? por_cfg : por_config_bit;
    next_por_cfg_valid = 1'b1;
  end

  assign detector_active   = en | (por_cfg_valid & ~por_cfg);
  assign next_sense_enable = detector_active;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en            <= `ZCDL_RST_BIT;
      level_invert_bit           <= `ZCDL_RST_BIT;
      rise_en       <= `ZCDL_RST_BIT;
      fall_en       <= `ZCDL_RST_BIT;
      flag          <= `ZCDL_RST_BIT;
      ie            <= `ZCDL_RST_BIT;
      global_irq_enable           <= `ZCDL_RST_BIT;
      peripheral_group_irq_enable          <= `ZCDL_RST_BIT;
      por_cfg       <= `ZCDL_RST_CFG;
      por_cfg_valid <= `ZCDL_RST_BIT;
      sense_enable  <= `ZCDL_RST_BIT;
    end else begin
      en            <= next_en;
      level_invert_bit           <= next_pol;
      rise_en       <= next_rise_en;
      fall_en       <= next_fall_en;
      flag          <= next_flag;
      ie            <= next_ie;
      global_irq_enable           <= next_gie;
      peripheral_group_irq_enable          <= next_peripheral_group_irq_enable;
      por_cfg       <= next_por_cfg;
      por_cfg_valid <= next_por_cfg_valid;
      sense_enable  <= next_sense_enable;
    end
  end

  // No sleep gating anywhere: detection and interrupt run on aclk alone
  assign irq            = flag & ie & peripheral_group_irq_enable & global_irq_enable;
  assign crossing_level = level;

  a_rise_sets_flag: assert property (
    @(posedge aclk) disable iff (!aresetn) (rise && rise_en) |=> flag)
    else $error("enabled rising edge did not set flag");

  a_fall_sets_flag: assert property (
    @(posedge aclk) disable iff (!aresetn) (fall && fall_en) |=> flag)
    else $error("enabled falling edge did not set flag");

  a_flag_has_cause: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!flag ##1 flag) |-> $past(set_evt))
    else $error("flag set without an enabled edge");

  a_irq_needs_all: assert property (
    @(posedge aclk) disable iff (!aresetn)
    irq == (flag && ie && peripheral_group_irq_enable && global_irq_enable))
    else $error("interrupt gating wrong");

  a_level_polarity: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_state == zcdl_pkg::zcdl_rd_idle && s_axi_arvalid &&
     s_axi_araddr == `ZCDL_OFF_CTRL) |=> (s_axi_rdata[`ZCDL_BIT_OUT] ==
     ($past(raw_sync) ^ $past(level_invert_bit))))
    else $error("readback level does not match sink state");

  a_invert_feeds_edge: assert property (
    @(posedge aclk) disable iff (!aresetn)
    level_invert_bit |-> (level == !raw_sync))
    else $error("inverted level wrong");

  a_pol_change_edge: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ($changed(level_invert_bit) && $stable(raw_sync)) |-> (rise || fall))
    else $error("polarity change gave no edge");

  a_flag_sticky: assert property (
    @(posedge aclk) disable iff (!aresetn) (flag && !clr_evt) |=> flag)
    else $error("flag cleared without software");

  a_set_beats_clear: assert property (
    @(posedge aclk) disable iff (!aresetn) (set_evt && clr_evt) |=> flag)
    else $error("edge lost during clear");

  a_pin_handover: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(en) |=> sense_enable [*2])
    else $error("pin not handed to sense stage");

  a_sync_two_stage: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 2) |-> (raw_sync == $past(sense_sink, 2)))
    else $error("synchroniser latency not two cycles");

  a_bvalid_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule

// ===== verif/zcdl_sense_model.sv
// Behavioural analog sense stage that stands at the detector pin
// Assumes above_ref says whether the applied pin voltage exceeds the reference
module zcdl_sense_model (
  input  wire logic above_ref,
  input  wire logic sense_enable,
  output logic      sense_sink
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_drive = 1'b0;
  // Sink above the reference, source below; a released pin shows the inverse of the last enabled reading
  always @(*) begin
    if (sense_enable) begin
      last_drive = above_ref;
    end
    sense_sink = sense_enable ? above_ref : ~last_drive;
  end
  // No sleep input, so only sense_enable changes the stage's behaviour
endmodule

// ===== verif/tb_top.sv
// Self-checking bench of the zero-cross logic over AXI4-Lite
// Assumes the design files and the sense stage model are compiled first
`include "zcdl_consts.svh"
`define TB_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, por_config_bit, above, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sense_sink, sense_enable;
  logic        crossing_level, irq, inv, rise, fall, nab, old_lvl, efl;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, rnd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] seed = 32'h0000002B;
  int          mismatches = 0;
  int          n_checks = 0;
  always #12.5 aclk = ~aclk;
  zcdl_top u_zcdl_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sense_sink(sense_sink),
    .por_config_bit(por_config_bit), .sense_enable(sense_enable),
    .crossing_level(crossing_level), .irq(irq));
  zcdl_sense_model u_zcdl_sense_model (.above_ref(above), .sense_enable(sense_enable),
    .sense_sink(sense_sink));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] ctrl_word(logic en, logic out, logic iv, logic rs,
                                            logic fl);
    return {24'h0, en, 1'b0, out, iv, 2'b00, rs, fl};
  endfunction
  function automatic logic flag_exp(logic o, logic n, logic rs, logic fl);
    return (rs & ~o & n) | (fl & o & ~n);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic aw, w, b;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic ar, rr;
    rr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!rr) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      rr = s_axi_rvalid & s_axi_rready;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
  endtask
  task automatic final_report;
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    final_report;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    // Response readies stay high, so back-to-back calls never drive them twice
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, above} = '0;
    s_axi_wstrb = 4'hF;
    por_config_bit = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    axr(`ZCDL_OFF_STAT, d, r);
    `TB_CHK("status", 32'h00000001, d)
    // Released pin shows a sinking level, so the output bit reads one
    axr(`ZCDL_OFF_CTRL, d, r);
    `TB_CHK("control", ctrl_word(0, 1, 0, 0, 0), d)
    axr(8'h40, d, r);
    `TB_CHK("unmapped rresp", `ZCDL_RESP_SLVERR, r)
    axw(8'h40, 32'h000000FF, r);
    `TB_CHK("unmapped bresp", `ZCDL_RESP_SLVERR, r)
    // Lane 0 disabled: write answered OKAY but ignored
    s_axi_wstrb <= 4'hE;
    axw(`ZCDL_OFF_CTRL, ctrl_word(1, 0, 1, 1, 1), r);
    s_axi_wstrb <= 4'hF;
    `TB_CHK("lane0 off bresp", `ZCDL_RESP_OKAY, r)
    axr(`ZCDL_OFF_CTRL, d, r);
    `TB_CHK("lane0 off control", ctrl_word(0, 1, 0, 0, 0), d)
    axw(`ZCDL_OFF_CTRL, ctrl_word(1, 0, 0, 0, 0), r);
    tick(2);
    `TB_CHK("sense_enable", 1'b1, sense_enable)
    // Random polarity, edge enables, masks and input steps
    for (int k = 0; k < 40; k++) begin
      rnd = xs();
      {nab, fall, rise, inv} = rnd[3:0];
      axw(`ZCDL_OFF_IEN, {31'h0, rnd[4]}, r);
      axw(`ZCDL_OFF_ICTL, {24'h0, rnd[5], rnd[6], 6'h00}, r);
      axw(`ZCDL_OFF_CTRL, ctrl_word(1, 0, inv, rise, fall), r);
      tick(4);
      axw(`ZCDL_OFF_FLAG, 32'h00000001, r);
      old_lvl = above ^ inv;
      above <= nab;
      tick(5);
      efl = flag_exp(old_lvl, nab ^ inv, rise, fall);
      axr(`ZCDL_OFF_CTRL, d, r);
      `TB_CHK("control", ctrl_word(1, nab ^ inv, inv, rise, fall), d)
      axr(`ZCDL_OFF_FLAG, d, r);
      `TB_CHK("flag", {31'h0, efl}, d)
      @(negedge aclk);
      `TB_CHK("irq", efl & rnd[4] & rnd[5] & rnd[6], irq)
      `TB_CHK("crossing_level", nab ^ inv, crossing_level)
      @(posedge aclk);
    end
    // Polarity change with the detector disabled
    axw(`ZCDL_OFF_CTRL, ctrl_word(0, 0, 0, 1, 1), r);
    tick(4);
    axw(`ZCDL_OFF_FLAG, 32'h00000001, r);
    axr(`ZCDL_OFF_FLAG, d, r);
    `TB_CHK("flag cleared", 32'h00000000, d)
    axw(`ZCDL_OFF_CTRL, ctrl_word(0, 0, 1, 1, 1), r);
    tick(3);
    axr(`ZCDL_OFF_FLAG, d, r);
    `TB_CHK("flag on invert", 32'h00000001, d)
    // Clear lands on the same edge as a new enabled edge
    axw(`ZCDL_OFF_CTRL, ctrl_word(1, 0, 0, 1, 1), r);
    tick(4);
    above <= ~above;
    tick(2);
    axw(`ZCDL_OFF_FLAG, 32'h00000001, r);
    axr(`ZCDL_OFF_FLAG, d, r);
    `TB_CHK("flag set wins", 32'h00000001, d)
    // Configuration strap low makes the detector active from reset
    aresetn <= 1'b0;
    por_config_bit <= 1'b0;
    tick(10);
    aresetn <= 1'b1;
    tick(3);
    `TB_CHK("sense_enable strap", 1'b1, sense_enable)
    axr(`ZCDL_OFF_STAT, d, r);
    `TB_CHK("status strap", 32'h00000002, d)
    final_report;
  end
endmodule
